// >>> tb_top.sv
// tb_top: directed apb and control-cycle tests of tls_supervisor
// assumes: package, design, host model and checker compiled first
`timescale 1ns/1ns
module tb_top import tls_pkg::*;;
	logic clk, rst_n, cy, ext, run, tm, psel, pen, pwr, rdy, er, tl, sl, tr;
	logic [7:0] pa;
	logic [31:0] pwd, prd, rv;
	logic signed [15:0] tq, spd, ai1, tqo;
	logic [15:0] ai2;
	logic [2:0] dout;
	int n_errors, n_tests;
	tls_supervisor DUT (.i_core_clk(clk), .i_arst_n(rst_n), .i_cycle(cy),
		.i_torque_ref(tq), .i_speed(spd), .i_analog_input_one(ai1),
		.i_analog_input_two(ai2), .i_external_limit_select_input(ext),
		.i_drive_running(run), .i_torque_mode(tm), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_pready(rdy), .o_prdata(prd),
		.o_pslverr(er), .o_torque_ref(tqo), .o_torque_limited_flag(tl),
		.o_speed_limited_flag(sl), .o_torque_reached_flag(tr));
	tls_host_do HOST (.i_flags({tr, sl, tl}), .o_do(dout));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
		n_tests++;
		if (seen !== x) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, x, seen);
		end
	endtask
	task automatic final_report;
		if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (rdy !== 1'b1 && k < 20);
		if (k >= 20) begin
			n_errors++;
			final_report();
		end
		rv = prd;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic e);
		apb(1'b1, a, {16'h0, d});
		chk("slave error", {31'h0, er}, {31'h0, e});
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("read data", rv, x);
	endtask
	// one control cycle, then outputs and flags {reached, speed, limited}
	task automatic cyc(input logic signed [15:0] r, input logic signed [15:0] x,
		input logic [2:0] f);
		@(posedge clk);
		tq <= r;
		cy <= 1'b1;
		@(posedge clk);
		cy <= 1'b0;
		#1;
		chk("torque out", {16'h0, tqo}, {16'h0, x});
		chk("flags", {29'h0, tr, sl, tl}, {29'h0, f});
	endtask
	task automatic src(input logic [15:0] v);
		wr(TLS_ADDR_SRC, v, 1'b0);
		repeat (3) @(posedge clk);
	endtask
	initial begin
		{rst_n, cy, ext, run, tm, psel, pen, pwr, pa, pwd, tq, spd, ai1, ai2} = '0;
		n_errors = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < TLS_NCFG; i++) rd(8'(4 * i + 4), {16'h0, TLS_CFG_DEF[i]});
		rd(TLS_ADDR_SRC, 32'h0);
		apb(1'b0, 8'h34, 32'h0);
		chk("unmapped error", {31'h0, er}, 32'h1);
		wr(TLS_ADDR_STATUS, 16'h0001, 1'b1);
		wr(8'h04, 16'h0FA1, 1'b1);
		wr(8'h1C, 16'h1F41, 1'b1);
		wr(TLS_ADDR_SRC, 16'h0004, 1'b1);
		wr(8'h24, 16'h0FA0, 1'b0);
		wr(8'h04, 16'h03E8, 1'b0);
		wr(8'h08, 16'h01F4, 1'b0);
		cyc(16'sh05DC, 16'sh03E8, 3'h1);
		cyc(-16'sh0258, -16'sh01F4, 3'h1);
		cyc(16'sh0320, 16'sh0320, 3'h0);
		run <= 1'b1;
		src(16'h0001);
		rd(TLS_ADDR_STATUS, 32'h80);
		run <= 1'b0;
		repeat (3) @(posedge clk);
		rd(TLS_ADDR_STATUS, 32'h20);
		wr(8'h0C, 16'h07D0, 1'b0);
		cyc(16'sh05DC, 16'sh03E8, 3'h1);
		ext <= 1'b1;
		cyc(16'sh05DC, 16'sh05DC, 3'h0);
		cyc(16'sh09C4, 16'sh07D0, 3'h1);
		cyc(-16'sh09C4, -16'sh09C4, 3'h0);
		ai1 <= -16'sh1388;
		ai2 <= 16'h2710;
		src(16'h0002);
		cyc(16'sh0384, 16'sh01F4, 3'h1);
		src(16'h0003);
		wr(8'h18, 16'h07D0, 1'b0);
		cyc(-16'sh04B0, -16'sh03E8, 3'h1);
		src(16'h0000);
		tm <= 1'b1;
		run <= 1'b1;
		spd <= 16'sh05DC;
		wr(8'h1C, 16'h03E8, 1'b0);
		cyc(16'sh0190, 16'sh0000, 3'h2);
		cyc(-16'sh0190, -16'sh0190, 3'h2);
		spd <= -16'sh05DC;
		cyc(-16'sh0190, -16'sh0190, 3'h0);
		wr(8'h20, 16'h03E8, 1'b0);
		cyc(-16'sh0190, 16'sh0000, 3'h2);
		spd <= -16'sh03E8;
		cyc(-16'sh0190, -16'sh0190, 3'h0);
		tm <= 1'b0;
		spd <= 16'sh1388;
		cyc(16'sh0190, 16'sh0190, 3'h0);
		wr(8'h24, 16'h0000, 1'b0);
		cyc(16'sh00FA, 16'sh00FA, 3'h4);
		cyc(-16'sh0096, -16'sh0096, 3'h4);
		cyc(16'sh0064, 16'sh0064, 3'h0);
		cyc(16'sh00C7, 16'sh00C7, 3'h0);
		cyc(-16'sh00C8, -16'sh00C8, 3'h4);
		chk("digital outputs", {29'h0, dout}, 32'h6);
		// mid-run reset: flags low, first setting word back to its default
		rst_n <= 1'b0;
		run <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk("reset flags", {29'h0, tr, sl, tl}, 32'h0);
		rd(8'h04, {16'h0, TLS_CFG_DEF[TLS_I_INT_P]});
		// analog limit above 300 % is capped
		wr(8'h14, 16'h1F40, 1'b0);
		src(16'h0002);
		cyc(16'sh0FA0, 16'sh0BB8, 3'h5);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		final_report();
	end
endmodule

// >>> tls_asserts.sv
// tls_asserts: port checks of the torque limit supervisor
// assumes: bound onto tls_supervisor, one clock domain
`timescale 1ns/1ns
module tls_asserts
	import tls_pkg::*;
(
	input wire logic                      i_core_clk,
	input wire logic                      i_arst_n,
	input wire logic                      i_cycle,
	input wire logic signed [TLS_TW-1:0]  i_torque_ref,
	input wire logic                      i_torque_mode,
	input wire logic                      i_psel,
	input wire logic                      i_penable,
	input wire logic                      o_pready,
	input wire logic        [31:0]        o_prdata,
	input wire logic signed [TLS_TW-1:0]  o_torque_ref,
	input wire logic                      o_torque_limited_flag,
	input wire logic                      o_speed_limited_flag,
	input wire logic                      o_torque_reached_flag
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	// apb answer timing
	a_pready_wait: assert property (i_psel && $rose(i_penable) |-> !o_pready ##1 o_pready)
		else $error("pready not one wait state after access");
	a_pready_pulse: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_prdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data outside answer");
	// data path updates only on control cycles
	a_out_hold: assert property (!$past(i_cycle) |-> $stable(o_torque_ref)
		&& $stable({o_torque_limited_flag, o_speed_limited_flag, o_torque_reached_flag}))
		else $error("outputs changed without control cycle");
	a_ref_cap: assert property (o_torque_ref <= signed'(TLS_TQ_CAP)
		&& o_torque_ref >= -signed'(TLS_TQ_CAP)) else $error("reference above cap");
	a_pass_through: assert property ($past(i_cycle) && !o_torque_limited_flag
		&& !o_speed_limited_flag |-> o_torque_ref == $past(i_torque_ref))
		else $error("unclamped reference altered");
	a_limited_clamps: assert property ($past(i_cycle) && o_torque_limited_flag
		|-> o_torque_ref != $past(i_torque_ref)) else $error("limited flag without clamp");
	a_speed_mode: assert property ($past(i_cycle) && !$past(i_torque_mode)
		|-> !o_speed_limited_flag) else $error("speed flag outside torque mode");
	a_flags_reset: assert property ($rose(i_arst_n) |-> !o_torque_reached_flag
		&& !o_torque_limited_flag) else $error("flags not low after reset");
endmodule
bind tls_supervisor tls_asserts CHK (.*);

// >>> tls_host_do.sv
// tls_host_do: host side digital outputs driven by the supervisor flags
// assumes: flags are levels; a POL bit high means that output is active high
`timescale 1ns/1ns
module tls_host_do
	import tls_pkg::*;
#(
	parameter logic [2:0] POL = 3'h5
)(
	input  wire tls_flags_t i_flags,
	output logic [2:0]      o_do
);
	// bits carry codes 17, 13, 16 with the chosen polarity
	assign o_do = i_flags ^ ~POL;
endmodule

// >>> tls_pkg.sv
// tls_pkg: constants, register map and carriers of the torque limit supervisor
// assumes: one 10 MHz core clock, apb slave with 32-bit data
package tls_pkg;

	// ------------------------------------------------------------
	// torque and speed units
	// ------------------------------------------------------------
	localparam int          TLS_TW       = 16;       // torque reference width, 0.1 % steps
	localparam int          TLS_SW       = 16;       // speed width, rpm
	localparam logic [15:0] TLS_TQ_CAP   = 16'h0BB8; // 300.0 % of rated torque
	localparam logic [31:0] TLS_AI1_FULL = 32'h0000_2710; // 10000 mV full scale
	localparam logic [31:0] TLS_AI2_FULL = 32'h0000_4E20; // 20000 uA full scale

	// ------------------------------------------------------------
	// register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] TLS_ADDR_SRC    = 8'h00; // limit source select
	localparam logic [7:0] TLS_ADDR_CFG0   = 8'h04; // first of the setting words
	localparam logic [7:0] TLS_ADDR_STATUS = 8'h30; // flags and active source
	localparam logic [1:0] TLS_SRC_RESET   = 2'h0;
	localparam logic [1:0] TLS_SRC_MAX     = 2'h3;

	// setting word indices, word n sits at TLS_ADDR_CFG0 + 4n
	localparam int TLS_NCFG     = 11;
	localparam int TLS_I_INT_P  = 0;  // internal_positive_torque_limit
	localparam int TLS_I_INT_N  = 1;  // internal_negative_torque_limit
	localparam int TLS_I_EXT_F  = 2;  // external_forward_torque_limit
	localparam int TLS_I_EXT_R  = 3;  // external_reverse_torque_limit
	localparam int TLS_I_FS_V   = 4;  // torque_at_full_scale_voltage
	localparam int TLS_I_FS_I   = 5;  // torque_at_full_scale_current
	localparam int TLS_I_SPD_P  = 6;  // positive_speed_limit
	localparam int TLS_I_SPD_N  = 7;  // negative_speed_limit
	localparam int TLS_I_BASE   = 8;  // torque_reached_base
	localparam int TLS_I_SET    = 9;  // torque_reached_set_offset
	localparam int TLS_I_CLR    = 10; // torque_reached_clear_offset

	localparam logic [15:0] TLS_CFG_DEF [TLS_NCFG] = '{
		16'h0BB8, 16'h0BB8, 16'h0BB8, 16'h0BB8, 16'h03E8, 16'h03E8,
		16'h0BB8, 16'h0BB8, 16'h0000, 16'h00C8, 16'h0064};
	localparam logic [15:0] TLS_CFG_MAX [TLS_NCFG] = '{
		16'h0FA0, 16'h0FA0, 16'h0FA0, 16'h0FA0, 16'h1F40, 16'h1F40,
		16'h1F40, 16'h1F40, 16'h0FA0, 16'h0FA0, 16'h0FA0};

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic torque_reached;
		logic speed_limited;
		logic torque_limited;
	} tls_flags_t;

	typedef struct packed {
		logic        sel;
		logic        write;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tls_apb_req_t;

endpackage

// >>> tls_supervisor.sv
// tls_supervisor: torque limit selection, clamping, torque-mode speed limit
// and the three status flags, with an apb register file
// assumes: inputs synchronous to i_core_clk, i_cycle pulses once per
// control cycle, analog inputs already offset/dead-zone corrected
`timescale 1ns/1ns

module tls_supervisor
	import tls_pkg::*;
(
	input  wire logic                 i_core_clk,
	input  wire logic                 i_arst_n,
	input  wire logic                 i_cycle,
	input  wire logic signed [TLS_TW-1:0] i_torque_ref,
	input  wire logic signed [TLS_SW-1:0] i_speed,
	input  wire logic signed [15:0]   i_analog_input_one,
	input  wire logic        [15:0]   i_analog_input_two,
	input  wire logic                 i_external_limit_select_input,
	input  wire logic                 i_drive_running,
	input  wire logic                 i_torque_mode,
	input  wire logic                 i_psel,
	input  wire logic                 i_penable,
	input  wire logic                 i_pwrite,
	input  wire logic        [7:0]    i_paddr,
	input  wire logic        [31:0]   i_pwdata,
	output logic                      o_pready,
	output logic             [31:0]   o_prdata,
	output logic                      o_pslverr,
	output logic signed [TLS_TW-1:0]  o_torque_ref,
	output logic                      o_torque_limited_flag,
	output logic                      o_speed_limited_flag,
	output logic                      o_torque_reached_flag
);

	// ------------------------------------------------------------
	// apb slave: one wait state, all answers registered
	// ------------------------------------------------------------
	tls_apb_req_t     req;
	logic [15:0]      cfg [TLS_NCFG];
	logic [15:0]      next_cfg [TLS_NCFG];
	logic [1:0]       src_pend;
	logic [1:0]       next_src_pend;
	logic [1:0]       src_act;
	logic [1:0]       next_src_act;
	logic             next_pready;
	logic [31:0]      next_prdata;
	logic             next_pslverr;
	logic             acc;
	logic             wr_done;
	logic [3:0]       widx;
	logic             cfg_hit;
	tls_flags_t       flags;

	assign req = '{sel: i_psel, write: i_pwrite, addr: i_paddr, wdata: i_pwdata};
	assign acc = req.sel & i_penable;
	assign wr_done = acc & o_pready & req.write;
	assign widx = 4'((req.addr - TLS_ADDR_CFG0) >> 2);
	assign cfg_hit = (req.addr[1:0] == 2'h0) && (req.addr >= TLS_ADDR_CFG0)
		&& (widx < 4'(TLS_NCFG));
	assign flags = '{torque_reached: o_torque_reached_flag,
		speed_limited: o_speed_limited_flag, torque_limited: o_torque_limited_flag};

	// answer generation; writes take effect at the edge that sees pready
	always_comb begin
		next_pready  = acc & ~o_pready;
		next_prdata  = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (acc && !o_pready) begin
			if (req.addr == TLS_ADDR_SRC) begin
				next_prdata  = {28'h000_0000, src_act, src_pend};
				next_pslverr = req.write && (req.wdata > 32'(TLS_SRC_MAX));
			end else if (cfg_hit) begin
				next_prdata  = {16'h0000, cfg[widx]};
				next_pslverr = req.write && (req.wdata > 32'(TLS_CFG_MAX[widx]));
			end else if (req.addr == TLS_ADDR_STATUS) begin
				next_prdata  = {24'h00_0000, i_drive_running, src_act, 2'h0, flags};
				next_pslverr = req.write;
			end else begin
				next_pslverr = 1'b1; // unmapped
			end
		end
	end

	// source select: written any time, adopted only while stopped
	always_comb begin
		next_src_pend = src_pend;
		if (wr_done && !o_pslverr && req.addr == TLS_ADDR_SRC) begin
			next_src_pend = req.wdata[1:0];
		end
		next_src_act = i_drive_running ? src_act : src_pend;
	end

	// setting words, each changeable during operation
	genvar g;
	generate
		for (g = 0; g < TLS_NCFG; g++) begin : g_cfg
			always_comb begin
				next_cfg[g] = cfg[g];
				if (wr_done && !o_pslverr && cfg_hit && widx == 4'(g)) begin
					next_cfg[g] = req.wdata[15:0];
				end
			end
			always_ff @(posedge i_core_clk or negedge i_arst_n) begin
				if (!i_arst_n) begin
					cfg[g] <= TLS_CFG_DEF[g];
				end else begin
					cfg[g] <= next_cfg[g];
				end
			end
		end
	endgenerate

	// bus and select registers
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h0000_0000;
			o_pslverr <= 1'b0;
			src_pend  <= TLS_SRC_RESET;
			src_act   <= TLS_SRC_RESET;
		end else begin
			o_pready  <= next_pready;
			o_prdata  <= next_prdata;
			o_pslverr <= next_pslverr;
			src_pend  <= next_src_pend;
			src_act   <= next_src_act;
		end
	end

	// ------------------------------------------------------------
	// torque limit selection
	// ------------------------------------------------------------
	logic [31:0] ai1_mag;
	logic [31:0] ai_lim;
	logic [15:0] pos_raw;
	logic [15:0] neg_raw;
	logic [15:0] pos_lim;
	logic [15:0] neg_lim;

	// analog magnitudes scaled against their full-scale settings
	always_comb begin
		ai1_mag = i_analog_input_one[15] ? 32'(-32'(i_analog_input_one))
			: 32'(i_analog_input_one);
		if (ai1_mag > TLS_AI1_FULL) begin
			ai1_mag = TLS_AI1_FULL;
		end
		if (src_act == 2'h2) begin
			ai_lim = (ai1_mag * 32'(cfg[TLS_I_FS_V])) / TLS_AI1_FULL;
		end else begin
			ai_lim = (32'(i_analog_input_two) * 32'(cfg[TLS_I_FS_I])) / TLS_AI2_FULL;
		end
		unique case (src_act)
			2'h0: begin
				pos_raw = cfg[TLS_I_INT_P];
				neg_raw = cfg[TLS_I_INT_N];
			end
			2'h1: begin
				pos_raw = i_external_limit_select_input ? cfg[TLS_I_EXT_F]
					: cfg[TLS_I_INT_P];
				neg_raw = i_external_limit_select_input ? cfg[TLS_I_EXT_R]
					: cfg[TLS_I_INT_N];
			end
			default: begin
				pos_raw = (ai_lim > 32'(TLS_TQ_CAP)) ? TLS_TQ_CAP : ai_lim[15:0];
				neg_raw = pos_raw;
			end
		endcase
		// single limit pair, never above 300 %
		pos_lim = (pos_raw > TLS_TQ_CAP) ? TLS_TQ_CAP : pos_raw;
		neg_lim = (neg_raw > TLS_TQ_CAP) ? TLS_TQ_CAP : neg_raw;
	end

	// ------------------------------------------------------------
	// clamp, speed limit and flags, once per control cycle
	// ------------------------------------------------------------
	logic signed [TLS_TW-1:0] next_torque_ref;
	logic signed [TLS_TW-1:0] clamped;
	logic                     next_tq_lim;
	logic                     next_spd_lim;
	logic                     next_reached;
	logic                     over_pos;
	logic                     over_neg;
	logic [15:0]              mag;
	logic [15:0]              set_thr;
	logic [15:0]              clr_thr;

	always_comb begin
		next_torque_ref = o_torque_ref;
		next_tq_lim     = o_torque_limited_flag;
		next_spd_lim    = o_speed_limited_flag;
		next_reached    = o_torque_reached_flag;
		clamped         = i_torque_ref;
		over_pos        = i_speed > $signed({1'b0, cfg[TLS_I_SPD_P][14:0]});
		over_neg        = i_speed < -$signed({1'b0, cfg[TLS_I_SPD_N][14:0]});
		set_thr         = cfg[TLS_I_BASE] + cfg[TLS_I_SET];
		clr_thr         = cfg[TLS_I_BASE] + cfg[TLS_I_CLR];
		if (i_torque_ref > $signed(pos_lim)) begin
			clamped = $signed(pos_lim);
		end else if (i_torque_ref < -$signed(neg_lim)) begin
			clamped = -$signed(neg_lim);
		end
		// torque mode: no further drive past the directional speed limit
		if (i_torque_mode && ((over_pos && clamped > 0) || (over_neg && clamped < 0))) begin
			clamped = '0;
		end
		mag = clamped[TLS_TW-1] ? 16'(-clamped) : 16'(clamped);
		if (i_cycle) begin
			next_torque_ref = clamped;
			next_tq_lim     = (i_torque_ref > $signed(pos_lim))
				|| (i_torque_ref < -$signed(neg_lim));
			next_spd_lim    = i_torque_mode && (over_pos || over_neg);
			if (clr_thr >= set_thr) begin
				next_reached = mag >= set_thr;
			end else if (mag >= set_thr) begin
				next_reached = 1'b1;
			end else if (mag <= clr_thr) begin
				next_reached = 1'b0;
			end
		end
	end

	// flag and reference registers, flags feed the host's outputs
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_torque_ref          <= '0;
			o_torque_limited_flag <= 1'b0;
			o_speed_limited_flag  <= 1'b0;
			o_torque_reached_flag <= 1'b0;
		end else begin
			o_torque_ref          <= next_torque_ref;
			o_torque_limited_flag <= next_tq_lim;
			o_speed_limited_flag  <= next_spd_lim;
			o_torque_reached_flag <= next_reached;
		end
	end

endmodule
